// *** include/hap_defs.svh ***
// Constants of the haptic interrupt and drive configuration register bank.
// Assumes a 20 MHz device clock and a serial host on the two-wire pins.
`ifndef HAP_DEFS_SVH
`define HAP_DEFS_SVH

// Register offsets
`define HAP_OFS_EVENT     8'h03
`define HAP_OFS_STATUS    8'h06
`define HAP_OFS_MASK      8'h07
`define HAP_OFS_HOST_CTRL 8'h08
`define HAP_OFS_PER_HI    8'h0A
`define HAP_OFS_PER_LO    8'h0B
`define HAP_OFS_V_NOM     8'h0C
`define HAP_OFS_V_CEIL    8'h0D

// Reset values
`define HAP_RST_MASK      8'h00
`define HAP_RST_EVENT     8'h00
`define HAP_RST_HOST_CTRL 8'h40
`define HAP_RST_PER_HI    8'h21
`define HAP_RST_PER_LO    7'h4F
`define HAP_RST_V_NOM     8'h5A
`define HAP_RST_V_CEIL    8'h78

// Field positions
`define HAP_BIT_WR_MODE   7
`define HAP_BIT_TO_EN     6
`define HAP_BIT_OC        7
`define HAP_BIT_ACT       6
`define HAP_BIT_WARN      5
`define HAP_BIT_SEQ_FAULT 4
`define HAP_BIT_HOT       3
`define HAP_BIT_SEQ_DONE  2
`define HAP_BIT_UVLO      1
`define HAP_BIT_SEQ_CONT  0
`define HAP_PER_LO_W      7
`define HAP_PER_HI_SCALE  128

// Physical units of the settings
`define HAP_PER_UNIT_PS   1333320
`define HAP_V_STEP_UV     23400

// Timing
`define HAP_CLK_KHZ       20000
`define HAP_TO_MS         35
`define HAP_TO_CYC        (`HAP_TO_MS * `HAP_CLK_KHZ)

`endif

// *** include/hap_pkg.sv ***
// Types shared by the haptic register bank and its users.
// Assumes hap_defs.svh for the numeric constants.
package hap_pkg;

   typedef enum logic [2:0] {
      HAP_IDLE,
      HAP_RX,
      HAP_ACK,
      HAP_TX,
      HAP_TXACK
   } hap_link_e;

   typedef enum logic [1:0] {
      HAP_ROLE_DEV,
      HAP_ROLE_REG,
      HAP_ROLE_DATA
   } hap_role_e;

   typedef struct packed {
      logic [14:0] res_period;
      logic [7:0]  v_nom;
      logic [7:0]  v_ceil;
   } hap_drive_cfg_s;

endpackage

// *** rtl/hap_sync.sv ***
// Two-stage synchroniser for asynchronous single-bit inputs.
// Assumes the inputs are levels that stay stable over several clock periods.
`timescale 1ns/1ps
module hap_sync #(
   parameter int W = 2
) (
   input  wire logic         ref_clk_i,
   input  wire logic         rst_i,
   input  wire logic [W-1:0] async_i,
   output logic      [W-1:0] sync_o
);

   logic [W-1:0] meta_ff;
   logic [W-1:0] sync_ff;

   genvar g;
   generate
      for (g = 0; g < W; g++)
      begin : g_bit
         always_ff @(posedge ref_clk_i or posedge rst_i)
         begin
            if (rst_i)
            begin
               meta_ff[g] <= 1'b1;
               sync_ff[g] <= 1'b1;
            end
            else
            begin
               meta_ff[g] <= async_i[g];
               sync_ff[g] <= meta_ff[g];
            end
         end
      end
   endgenerate

   assign sync_o = sync_ff;

endmodule

// *** rtl/hap_regs.sv ***
// Haptic interrupt and drive configuration registers behind a two-wire serial target.
// Assumes event pulses and live status come from logic on ref_clk_i; the pins
// are asynchronous and the pad combines sda_oe_o with an external pull-up.
`timescale 1ns/1ps
`include "hap_defs.svh"
module hap_regs #(
   parameter logic [6:0] DEV_ADDR    = 7'h4A,        // Arbitrary target address
   parameter int         TIMEOUT_CYC = `HAP_TO_CYC
) (
   input  wire logic                    ref_clk_i,
   input  wire logic                    rst_i,
   input  wire logic                    scl_i,
   input  wire logic                    sda_i,
   output logic                         sda_o,
   output logic                         sda_oe_o,
   input  wire logic [7:0]              event_set_i,
   input  wire logic [7:0]              status_live_i,
   output logic                         irq_o,
   output hap_pkg::hap_drive_cfg_s      drive_cfg_o
);

   import hap_pkg::*;

   localparam int         TW       = $clog2(TIMEOUT_CYC + 1);
   localparam logic [7:0] CTRL_RST = `HAP_RST_HOST_CTRL;

   ////////////////////////////////////////////////////////////////////////////
   // Pin sampling

   logic [1:0] pin_sync;
   logic       scl_s;
   logic       sda_s;
   logic       scl_q_ff;
   logic       sda_q_ff;
   logic       scl_rise;
   logic       scl_fall;
   logic       start_det;
   logic       stop_det;

   hap_sync #(
      .W         (2)
   ) u_sync (
      .ref_clk_i (ref_clk_i),
      .rst_i     (rst_i),
      .async_i   ({scl_i, sda_i}),
      .sync_o    (pin_sync)
   );

   assign scl_s     = pin_sync[1];
   assign sda_s     = pin_sync[0];
   assign scl_rise  = scl_s & ~scl_q_ff;
   assign scl_fall  = ~scl_s & scl_q_ff;
   assign start_det = scl_s & scl_q_ff & sda_q_ff & ~sda_s;
   assign stop_det  = scl_s & scl_q_ff & ~sda_q_ff & sda_s;

   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         scl_q_ff <= 1'b1;
         sda_q_ff <= 1'b1;
      end
      else
      begin
         scl_q_ff <= scl_s;
         sda_q_ff <= sda_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register storage declarations

   logic [7:0] mask_ff;
   logic [7:0] event_ff;
   logic       wr_mode_ff;
   logic       to_en_ff;
   logic [7:0] per_hi_ff;
   logic [6:0] per_lo_ff;
   logic [7:0] v_nom_ff;
   logic [7:0] v_ceil_ff;
   logic [7:0] status_ff;
   logic       irq_ff;

   ////////////////////////////////////////////////////////////////////////////
   // Serial target

   hap_link_e  state_ff;
   hap_link_e  nxt_state;
   hap_role_e  role_ff;
   hap_role_e  nxt_role;
   logic [3:0] cnt_ff;
   logic [3:0] nxt_cnt;
   logic [7:0] sh_ff;
   logic [7:0] nxt_sh;
   logic [7:0] ptr_ff;
   logic [7:0] nxt_ptr;
   logic       rw_ff;
   logic       nxt_rw;
   logic       oe_ff;
   logic       nxt_oe;
   logic [TW-1:0] to_ff;
   logic [TW-1:0] nxt_to;
   logic       wr_stb;
   logic [7:0] wr_data;
   logic [7:0] rd_val;

   always_comb
   begin
      case (ptr_ff)
         `HAP_OFS_EVENT:     rd_val = event_ff;
         `HAP_OFS_STATUS:    rd_val = status_ff;
         `HAP_OFS_MASK:      rd_val = mask_ff;
         `HAP_OFS_HOST_CTRL: rd_val = {wr_mode_ff, to_en_ff, 6'h00};
         `HAP_OFS_PER_HI:    rd_val = per_hi_ff;
         `HAP_OFS_PER_LO:    rd_val = {1'b0, per_lo_ff};
         `HAP_OFS_V_NOM:     rd_val = v_nom_ff;
         `HAP_OFS_V_CEIL:    rd_val = v_ceil_ff;
         default:            rd_val = 8'h00;
      endcase
   end

   always_comb
   begin
      nxt_state = state_ff;
      nxt_role  = role_ff;
      nxt_cnt   = cnt_ff;
      nxt_sh    = sh_ff;
      nxt_ptr   = ptr_ff;
      nxt_rw    = rw_ff;
      nxt_oe    = oe_ff;
      nxt_to    = '0;
      wr_stb    = 1'b0;
      wr_data   = sh_ff;
      // Timeout only runs inside a transfer; an idle bus never trips it
      if (state_ff != HAP_IDLE && to_en_ff && !scl_fall)
      begin
         nxt_to = to_ff + 1'b1;
      end
      case (state_ff)
         HAP_IDLE:
         begin
            nxt_oe = 1'b0;
         end
         HAP_RX:
         begin
            if (scl_rise)
            begin
               nxt_sh  = {sh_ff[6:0], sda_s};
               nxt_cnt = cnt_ff + 4'h1;
            end
            else if (scl_fall && cnt_ff == 4'h8)
            begin
               nxt_cnt   = 4'h0;
               nxt_state = HAP_ACK;
               nxt_oe    = 1'b1;
               case (role_ff)
                  HAP_ROLE_DEV:
                  begin
                     nxt_rw = sh_ff[0];
                     if (sh_ff[7:1] != DEV_ADDR)
                     begin
                        nxt_state = HAP_IDLE;
                        nxt_oe    = 1'b0;
                     end
                  end
                  HAP_ROLE_REG:
                  begin
                     nxt_ptr = sh_ff;
                  end
                  default:
                  begin
                     wr_stb  = 1'b1;
                     nxt_ptr = ptr_ff + 8'h01;
                  end
               endcase
            end
         end
         HAP_ACK:
         begin
            if (scl_fall)
            begin
               if (role_ff == HAP_ROLE_DEV && rw_ff)
               begin
                  nxt_sh    = rd_val;
                  nxt_ptr   = ptr_ff + 8'h01;
                  nxt_oe    = ~rd_val[7];
                  nxt_state = HAP_TX;
               end
               else
               begin
                  nxt_oe    = 1'b0;
                  nxt_state = HAP_RX;
                  if (role_ff == HAP_ROLE_DEV)
                  begin
                     nxt_role = HAP_ROLE_REG;
                  end
                  else if (role_ff == HAP_ROLE_DATA && wr_mode_ff)
                  begin
                     nxt_role = HAP_ROLE_REG;
                  end
                  else
                  begin
                     nxt_role = HAP_ROLE_DATA;
                  end
               end
            end
         end
         HAP_TX:
         begin
            if (scl_rise)
            begin
               nxt_cnt = cnt_ff + 4'h1;
            end
            else if (scl_fall)
            begin
               if (cnt_ff == 4'h8)
               begin
                  nxt_cnt   = 4'h0;
                  nxt_oe    = 1'b0;
                  nxt_state = HAP_TXACK;
               end
               else
               begin
                  nxt_sh = {sh_ff[6:0], 1'b0};
                  nxt_oe = ~sh_ff[6];
               end
            end
         end
         HAP_TXACK:
         begin
            // Host acknowledge keeps the read going; no-acknowledge ends it
            if (scl_rise && sda_s)
            begin
               nxt_state = HAP_IDLE;
            end
            else if (scl_fall)
            begin
               nxt_sh    = rd_val;
               nxt_ptr   = ptr_ff + 8'h01;
               nxt_oe    = ~rd_val[7];
               nxt_state = HAP_TX;
            end
         end
         default:
         begin
            nxt_state = HAP_IDLE;
            nxt_oe    = 1'b0;
         end
      endcase
      if (start_det)
      begin
         nxt_state = HAP_RX;
         nxt_role  = HAP_ROLE_DEV;
         nxt_cnt   = 4'h0;
         nxt_oe    = 1'b0;
         nxt_to    = '0;
      end
      else if (stop_det || (to_en_ff && to_ff >= TW'(TIMEOUT_CYC)))
      begin
         nxt_state = HAP_IDLE;
         nxt_cnt   = 4'h0;
         nxt_oe    = 1'b0;
         nxt_to    = '0;
      end
   end

   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         state_ff <= HAP_IDLE;
         role_ff  <= HAP_ROLE_DEV;
         cnt_ff   <= 4'h0;
         sh_ff    <= 8'h00;
         ptr_ff   <= 8'h00;
         rw_ff    <= 1'b0;
         oe_ff    <= 1'b0;
         to_ff    <= '0;
      end
      else
      begin
         state_ff <= nxt_state;
         role_ff  <= nxt_role;
         cnt_ff   <= nxt_cnt;
         sh_ff    <= nxt_sh;
         ptr_ff   <= nxt_ptr;
         rw_ff    <= nxt_rw;
         oe_ff    <= nxt_oe;
         to_ff    <= nxt_to;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register bank

   logic [7:0] nxt_mask;
   logic [7:0] nxt_event;
   logic       nxt_wr_mode;
   logic       nxt_to_en;
   logic [7:0] nxt_per_hi;
   logic [6:0] nxt_per_lo;
   logic [7:0] nxt_v_nom;
   logic [7:0] nxt_v_ceil;
   logic [7:0] w1c;

   always_comb
   begin
      nxt_mask    = mask_ff;
      nxt_wr_mode = wr_mode_ff;
      nxt_to_en   = to_en_ff;
      nxt_per_hi  = per_hi_ff;
      nxt_per_lo  = per_lo_ff;
      nxt_v_nom   = v_nom_ff;
      nxt_v_ceil  = v_ceil_ff;
      w1c         = 8'h00;
      if (wr_stb)
      begin
         case (ptr_ff)
            `HAP_OFS_EVENT:     w1c = wr_data;
            `HAP_OFS_MASK:      nxt_mask = wr_data;
            `HAP_OFS_HOST_CTRL:
            begin
               nxt_wr_mode = wr_data[`HAP_BIT_WR_MODE];
               nxt_to_en   = wr_data[`HAP_BIT_TO_EN];
            end
            `HAP_OFS_PER_HI:    nxt_per_hi = wr_data;
            `HAP_OFS_PER_LO:    nxt_per_lo = wr_data[`HAP_PER_LO_W-1:0];
            `HAP_OFS_V_NOM:     nxt_v_nom = wr_data;
            `HAP_OFS_V_CEIL:    nxt_v_ceil = wr_data;
            default:            w1c = 8'h00;
         endcase
      end
      // A new event in the clearing cycle survives the clear
      nxt_event = (event_ff & ~w1c) | event_set_i;
   end

   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         mask_ff    <= `HAP_RST_MASK;
         event_ff   <= `HAP_RST_EVENT;
         wr_mode_ff <= CTRL_RST[`HAP_BIT_WR_MODE];
         to_en_ff   <= CTRL_RST[`HAP_BIT_TO_EN];
         per_hi_ff  <= `HAP_RST_PER_HI;
         per_lo_ff  <= `HAP_RST_PER_LO;
         v_nom_ff   <= `HAP_RST_V_NOM;
         v_ceil_ff  <= `HAP_RST_V_CEIL;
         status_ff  <= 8'h00;
         irq_ff     <= 1'b0;
      end
      else
      begin
         mask_ff    <= nxt_mask;
         event_ff   <= nxt_event;
         wr_mode_ff <= nxt_wr_mode;
         to_en_ff   <= nxt_to_en;
         per_hi_ff  <= nxt_per_hi;
         per_lo_ff  <= nxt_per_lo;
         v_nom_ff   <= nxt_v_nom;
         v_ceil_ff  <= nxt_v_ceil;
         status_ff  <= status_live_i;
         irq_ff     <= |(event_ff & ~mask_ff);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs

   // Open drain: the pad only ever pulls low, the pull-up makes the one
   logic sda_lvl_ff;

   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         sda_lvl_ff <= 1'b0;
      end
      else
      begin
         sda_lvl_ff <= 1'b0;
      end
   end

   assign sda_o    = sda_lvl_ff;
   assign sda_oe_o = oe_ff;
   assign irq_o    = irq_ff;
   // Period counts in 1333.32 ns steps: hi * 128 + lo
   assign drive_cfg_o.res_period = {per_hi_ff, per_lo_ff};
   assign drive_cfg_o.v_nom      = v_nom_ff;
   assign drive_cfg_o.v_ceil     = v_ceil_ff;

endmodule

// *** testbench/hap_regs_sva.sv ***
// Port checker for the haptic register bank.
// Assumes it is bound onto hap_regs with the same TIMEOUT_CYC.
`timescale 1ns/1ps
module hap_regs_sva #(
   parameter int TIMEOUT_CYC = 200
) (
   input wire logic                    ref_clk_i,
   input wire logic                    rst_i,
   input wire logic                    scl_i,
   input wire logic                    sda_i,
   input wire logic                    sda_o,
   input wire logic                    sda_oe_o,
   input wire logic [7:0]              event_set_i,
   input wire logic [7:0]              status_live_i,
   input wire logic                    irq_o,
   input wire hap_pkg::hap_drive_cfg_s drive_cfg_o
);
   import hap_pkg::*;
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (rst_i);
   ////////////////////////////////////////
   // Cycles SDA is held low by the device while SCL stays parked low
   int unsigned hold_ff;
   int unsigned nxt_hold;
   always_comb
   begin
      nxt_hold = (sda_oe_o && !scl_i) ? hold_ff + 1 : 0;
   end
   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
         hold_ff <= 0;
      else
         hold_ff <= nxt_hold;
   end
   ////////////////////////////////////////
   // A committed write is always followed by the device's acknowledge
   sequence s_ack;
      ##[0:8] sda_oe_o;
   endsequence
   property p_cfg_reset;
      $fell(rst_i) |-> drive_cfg_o == {15'h10CF, 8'h5A, 8'h78} && !irq_o && !sda_oe_o;
   endproperty
   property p_irq_rise;
      $rose(irq_o) |-> $past(|event_set_i) || $past(|event_set_i, 2);
   endproperty
   property p_irq_fall;
      $fell(irq_o) |-> s_ack;
   endproperty
   property p_cfg_ack;
      $changed(drive_cfg_o) |-> s_ack;
   endproperty
   property p_oe_scl;
      $changed(sda_oe_o) |-> !$past(scl_i);
   endproperty
   property p_oe_width;
      $rose(sda_oe_o) |-> sda_oe_o [*4];
   endproperty
   property p_sda_zero;
      sda_o == 1'b0;
   endproperty
   property p_timeout;
      hold_ff < TIMEOUT_CYC + 8;
   endproperty
   a_cfg_reset: assert property (p_cfg_reset) else $error("bad reset state");
   a_irq_rise: assert property (p_irq_rise) else $error("irq without event");
   a_irq_fall: assert property (p_irq_fall) else $error("irq cleared off bus");
   a_cfg_ack: assert property (p_cfg_ack) else $error("config moved off bus");
   a_oe_scl: assert property (p_oe_scl) else $error("sda moved with scl high");
   a_oe_width: assert property (p_oe_width) else $error("sda drive too short");
   a_sda_zero: assert property (p_sda_zero) else $error("sda data not low");
   a_timeout: assert property (p_timeout) else $error("bus timeout missed");
endmodule

// *** testbench/hap_host.sv ***
// Host model: two-wire controller driving the bank's serial pins.
// Assumes a pull-up on SDA; the bench folds all drivers into one wire.
`timescale 1ns/1ps
module hap_host (
   output logic      scl_o,
   output logic      sda_low_o,
   input  wire logic sda_i
);
   // SCL parks high between frames, SDA released
   initial
   begin
      scl_o     = 1'b1;
      sda_low_o = 1'b0;
   end
   // One 400 ns SCL period; dr = 1 releases SDA
   task automatic clk(input logic dr, output logic rd);
      sda_low_o = !dr;
      #100 scl_o = 1'b1;
      #100 rd = sda_i;
      #100 scl_o = 1'b0;
      #100;
   endtask
   // Odd offset keeps SCL edges off the device clock edges
   task automatic start();
      #7 sda_low_o = 1'b0;
      #100 scl_o = 1'b1;
      #100 sda_low_o = 1'b1;
      #100 scl_o = 1'b0;
      #100;
   endtask
   task automatic stop();
      sda_low_o = 1'b1;
      #100 scl_o = 1'b1;
      #100 sda_low_o = 1'b0;
      #200;
   endtask
   task automatic put(input logic [7:0] b, output logic ack);
      logic rd;
      for (int i = 7; i >= 0; i--)
         clk(b[i], rd);
      clk(1'b1, rd);
      ack = !rd;
   endtask
   task automatic get(input logic last, output logic [7:0] b);
      logic rd;
      for (int i = 7; i >= 0; i--)
         clk(1'b1, b[i]);
      clk(last, rd);
   endtask
endmodule

// *** testbench/tb.sv ***
// Self-checking bench for the haptic register bank with a host model.
// Assumes hap_pkg is compiled first and hap_defs.svh is on the include path.
`timescale 1ns/1ps
module tb;
   import hap_pkg::*;
   localparam int         TO_CYC = 200;
   localparam logic [6:0] DEV    = 7'h4A;
   logic           ref_clk_i;
   logic           rst_i;
   logic [7:0]     event_set_i;
   logic [7:0]     status_live_i;
   logic           scl;
   logic           sda_low;
   logic           sda_oe_o;
   logic           irq_o;
   logic [7:0]     b;
   logic           a;
   hap_drive_cfg_s cfg;
   int             err_total;
   int             checks_done;
   int             cyc;
   wire            sda = !(sda_low || sda_oe_o);
   hap_regs #(.DEV_ADDR(DEV), .TIMEOUT_CYC(TO_CYC)) dut (
      .ref_clk_i     (ref_clk_i),
      .rst_i         (rst_i),
      .scl_i         (scl),
      .sda_i         (sda),
      .sda_o         (),
      .sda_oe_o      (sda_oe_o),
      .event_set_i   (event_set_i),
      .status_live_i (status_live_i),
      .irq_o         (irq_o),
      .drive_cfg_o   (cfg)
   );
   hap_host host (.scl_o(scl), .sda_low_o(sda_low), .sda_i(sda));
   ////////////////////////////////////////
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         err_total++;
         $display("wrong value at %0t: %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] r, input logic [7:0] d[$]);
      host.start();
      host.put({DEV, 1'b0}, a);
      host.put(r, a);
      foreach (d[i])
         host.put(d[i], a);
      host.stop();
   endtask
   task automatic rd(input logic [7:0] r, input int n, output logic [7:0] q[$]);
      q = {};
      host.start();
      host.put({DEV, 1'b0}, a);
      host.put(r, a);
      host.start();
      host.put({DEV, 1'b1}, a);
      for (int i = 0; i < n; i++)
      begin
         host.get(i == n - 1, b);
         q.push_back(b);
      end
      host.stop();
   endtask
   task automatic rdv(input logic [7:0] r);
      logic [7:0] q[$];
      rd(r, 1, q);
      b = q[0];
   endtask
   task automatic pulse(input logic [7:0] e);
      @(posedge ref_clk_i) event_set_i <= e;
      @(posedge ref_clk_i) event_set_i <= 8'h00;
      repeat (3) @(posedge ref_clk_i);
   endtask
   ////////////////////////////////////////
   task automatic t_reset();
      logic [7:0] q[$];
      chk(cfg, {15'h10CF, 8'h5A, 8'h78});
      rd(8'h07, 7, q);
      chk(q[0], 8'h00);
      chk(q[1], 8'h40);
      chk(q[2], 8'h00);
      chk(q[3], 8'h21);
      chk(q[4], 8'h4F);
      chk(q[5], 8'h5A);
      chk(q[6], 8'h78);
   endtask
   task automatic t_modes();
      wr(8'h0A, '{8'h12, 8'hFF, 8'h34, 8'hA6});
      chk(cfg.res_period, 15'h12 * 15'd128 + 15'h7F);
      chk(cfg.v_nom, 8'h34);
      chk(cfg.v_ceil, 8'hA6);
      rdv(8'h0B);
      chk(b, 8'h7F);
      // Repeat mode: register address before every byte
      wr(8'h08, '{8'hC0});
      wr(8'h0C, '{8'h11, 8'h0D, 8'h22, 8'h08, 8'h40});
      chk(cfg.v_nom, 8'h11);
      chk(cfg.v_ceil, 8'h22);
      rdv(8'h08);
      chk(b, 8'h40);
   endtask
   task automatic t_status();
      @(posedge ref_clk_i) status_live_i <= 8'h1D;
      rdv(8'h06);
      chk(b, 8'h1D);
      @(posedge ref_clk_i) status_live_i <= 8'h02;
      rdv(8'h06);
      chk(b, 8'h02);
   endtask
   task automatic t_events();
      for (int i = 0; i < 8; i++)
      begin
         wr(8'h07, '{~(8'h01 << i)});
         pulse(8'h01 << i);
         chk(irq_o, 1'b1);
         rdv(8'h03);
         chk(b, 8'h01 << i);
         wr(8'h03, '{8'h01 << i});
         chk(irq_o, 1'b0);
      end
      wr(8'h07, '{8'hFF});
      pulse(8'hFF);
      chk(irq_o, 1'b0);
      rdv(8'h03);
      chk(b, 8'hFF);
      wr(8'h03, '{8'hFF});
      wr(8'h07, '{8'h00});
   endtask
   task automatic t_timeout();
      // Stall SCL low while the device drives the first read bit
      host.start();
      host.put({DEV, 1'b0}, a);
      host.put(8'h07, a);
      host.start();
      host.put({DEV, 1'b1}, a);
      repeat (8) @(posedge ref_clk_i);
      chk(sda_oe_o, 1'b1);
      repeat (TO_CYC + 10) @(posedge ref_clk_i);
      chk(sda_oe_o, 1'b0);
      host.stop();
      rdv(8'h0C);
      chk(b, 8'h11);
   endtask
   task automatic t_no_timeout();
      // Timeout off: a long SCL stall inside a write must not drop the frame
      wr(8'h08, '{8'h00});
      host.start();
      host.put({DEV, 1'b0}, a);
      host.put(8'h0C, a);
      repeat (TO_CYC + 10) @(posedge ref_clk_i);
      #7;
      host.put(8'h3C, a);
      chk(a, 1'b1);
      host.stop();
      chk(cfg.v_nom, 8'h3C);
      wr(8'h08, '{8'h40});
   endtask
   ////////////////////////////////////////
   task automatic test_done();
      if (err_total == 0 && checks_done > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial
   begin
      ref_clk_i = 1'b0;
      forever #25 ref_clk_i = ~ref_clk_i;
   end
   always @(posedge ref_clk_i)
   begin
      cyc++;
      if (cyc == 40000)
      begin
         err_total++;
         test_done();
      end
   end
   initial
   begin
      rst_i         = 1'b1;
      event_set_i   = 8'h00;
      status_live_i = 8'h00;
      repeat (5) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      repeat (3) @(posedge ref_clk_i);
      t_reset();
      t_modes();
      t_status();
      t_events();
      t_timeout();
      t_no_timeout();
      test_done();
   end
endmodule
bind hap_regs hap_regs_sva #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_sva (
   .ref_clk_i     (ref_clk_i),
   .rst_i         (rst_i),
   .scl_i         (scl_i),
   .sda_i         (sda_i),
   .sda_o         (sda_o),
   .sda_oe_o      (sda_oe_o),
   .event_set_i   (event_set_i),
   .status_live_i (status_live_i),
   .irq_o         (irq_o),
   .drive_cfg_o   (drive_cfg_o)
);
